//--- design/mon_tag_pkg.sv
`default_nettype none
package mon_tag_pkg;
  // Instruction codes
  localparam logic [7:0] INSTR_ENTER_PROG = 8'h04;
  localparam logic [7:0] INSTR_EXIT_PROG = 8'h05;
  localparam logic [7:0] INSTR_REG_WRITE = 8'h51;
  localparam logic [7:0] INSTR_REG_READ = 8'h52;
  localparam logic [7:0] INSTR_TAG_ERASE = 8'h61;
  localparam logic [7:0] INSTR_TAG_REG_WRITE = 8'h62;
  localparam logic [7:0] INSTR_TAG_REG_READ = 8'h63;
  localparam logic [7:0] INSTR_TAG_ROW_PROGRAM = 8'h64;
  localparam logic [7:0] INSTR_TAG_ROW_READ = 8'h65;
  localparam logic [7:0] PROG_KEY_HIGH = 8'he5;
  localparam logic [7:0] PROG_KEY_LOW = 8'h3d;
  // Register addresses
  localparam logic [7:0] ADDR_MONITOR_SELECT = 8'h07;
  localparam logic [7:0] ADDR_MONITOR_RECORD = 8'h08;
  localparam logic [7:0] ADDR_OUTPUT_SOFTWARE_CONTROL = 8'h70;
  localparam logic [7:0] ADDR_TEMP_EXT1_HIGH_BYTE = 8'h80;
  localparam logic [7:0] ADDR_TEMP_EXT1_LOW_BYTE = 8'h81;
  localparam logic [7:0] ADDR_TEMP_EXT2_HIGH_BYTE = 8'h82;
  localparam logic [7:0] ADDR_TEMP_EXT2_LOW_BYTE = 8'h83;
  localparam logic [7:0] ADDR_TEMP_INTERNAL_HIGH_BYTE = 8'h84;
  localparam logic [7:0] ADDR_TEMP_INTERNAL_LOW_BYTE = 8'h85;
  localparam logic [7:0] ADDR_TEMP_ALARM_FIRST_COMPARATOR = 8'h86;
  localparam logic [7:0] ADDR_TEMP_ALARM_SECOND_COMPARATOR = 8'h87;
  // Field layout and reset values
  localparam int MON_SELECT_VALID_BIT = 7;
  localparam int MON_SELECT_WIDTH = 4;
  localparam int OUT_CTL_WIDTH = 6;
  localparam int TEMP_WIDTH = 11;
  localparam int TEMP_RAW_WIDTH = 12;
  localparam int TEMP_CHANNELS = 3;
  localparam logic [10:0] TEMP_OFF_CODE = 11'h700;
  localparam logic [10:0] TEMP_SAT_CODE = 11'h3ff;
  localparam logic signed [11:0] TEMP_SAT_LIMIT = 12'sh280;
  localparam logic [7:0] TAG_ERASED_BYTE = 8'hff;
  localparam logic [7:0] READ_FILL_BYTE = 8'hff;
  localparam logic [7:0] UNMAPPED_READ_BYTE = 8'h00;
  localparam logic [3:0] BYTE_IDX_MAX = 4'h8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TAG_LAST_BYTE = 3'h6;
  localparam logic [6:0] DEFAULT_TARGET_ADDR = 7'h40;

  typedef enum logic [2:0]
  {
    P_IDLE = 3'b000,
    P_ADDR = 3'b001,
    P_ADDR_ACK = 3'b010,
    P_WRITE = 3'b011,
    P_WR_ACK = 3'b100,
    P_READ = 3'b101,
    P_RD_ACK = 3'b110
  } phy_state_t;
endpackage
`default_nettype wire

//--- design/i2c_byte_if.sv
`default_nettype none
interface i2c_byte_if;
  logic start;
  logic stop;
  logic byte_valid;
  logic [7:0] byte_data;
  logic rd_take;
  logic [7:0] rd_data;
  modport phy (output start, output stop, output byte_valid, output byte_data, output rd_take, input rd_data);
  modport core (input start, input stop, input byte_valid, input byte_data, input rd_take, output rd_data);
endinterface
`default_nettype wire

//--- design/i2c_target_phy.sv
`default_nettype none
module i2c_target_phy
  import mon_tag_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = DEFAULT_TARGET_ADDR
)
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_in, // Bus data pin level
  output logic sda_oe, // Pull data low
  i2c_byte_if.phy bus // Byte events
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    phy_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic oe;
    logic start;
    logic stop;
    logic byte_valid;
    logic rd_take;
  } phy_s_t;

  phy_s_t s;
  phy_s_t next_s;
  logic scl;
  logic sda;
  logic rise;
  logic fall;

  assign scl = s.scl_s[1];
  assign sda = s.sda_s[1];
  assign rise = scl & ~s.scl_d;
  assign fall = ~scl & s.scl_d;

  always_comb
  begin
    next_s = s;
    next_s.scl_s = {s.scl_s[0], scl_in};
    next_s.sda_s = {s.sda_s[0], sda_in};
    next_s.scl_d = scl;
    next_s.sda_d = sda;
    next_s.start = 1'b0;
    next_s.stop = 1'b0;
    next_s.byte_valid = 1'b0;
    next_s.rd_take = 1'b0;
    if (scl && s.scl_d && s.sda_d && !sda)
    begin
      next_s.st = P_ADDR;
      next_s.bit_cnt = 4'h0;
      next_s.oe = 1'b0;
      next_s.start = 1'b1;
    end
    else if (scl && s.scl_d && !s.sda_d && sda)
    begin
      next_s.st = P_IDLE;
      next_s.oe = 1'b0;
      next_s.stop = 1'b1;
    end
    else
    begin
      case (s.st)
        P_ADDR, P_WRITE:
        begin
          if (rise)
          begin
            next_s.shreg = {s.shreg[6:0], sda};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
          else if (fall && s.bit_cnt == BITS_PER_BYTE)
          begin
            if (s.st == P_WRITE)
            begin
              next_s.byte_valid = 1'b1;
              next_s.oe = 1'b1;
              next_s.st = P_WR_ACK;
            end
            else if (s.shreg[7:1] == TARGET_ADDR)
            begin
              next_s.oe = 1'b1;
              next_s.rw = s.shreg[0];
              next_s.st = P_ADDR_ACK;
            end
            else
            begin
              next_s.st = P_IDLE;
            end
          end
        end
        P_ADDR_ACK:
        begin
          if (fall)
          begin
            next_s.bit_cnt = 4'h0;
            if (s.rw)
            begin
              next_s.shreg = bus.rd_data;
              next_s.rd_take = 1'b1;
              next_s.oe = ~bus.rd_data[7];
              next_s.st = P_READ;
            end
            else
            begin
              next_s.oe = 1'b0;
              next_s.st = P_WRITE;
            end
          end
        end
        P_WR_ACK:
        begin
          if (fall)
          begin
            next_s.oe = 1'b0;
            next_s.bit_cnt = 4'h0;
            next_s.st = P_WRITE;
          end
        end
        P_READ:
        begin
          if (rise)
          begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
          else if (fall)
          begin
            if (s.bit_cnt == BITS_PER_BYTE)
            begin
              next_s.oe = 1'b0;
              next_s.bit_cnt = 4'h0;
              next_s.st = P_RD_ACK;
            end
            else
            begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.oe = ~s.shreg[6];
            end
          end
        end
        P_RD_ACK:
        begin
          // Master ack keeps the read going, nack ends it
          if (rise)
          begin
            if (sda)
            begin
              next_s.st = P_IDLE;
            end
            else
            begin
              next_s.bit_cnt = 4'h1;
            end
          end
          else if (fall && s.bit_cnt == 4'h1)
          begin
            next_s.shreg = bus.rd_data;
            next_s.rd_take = 1'b1;
            next_s.oe = ~bus.rd_data[7];
            next_s.bit_cnt = 4'h0;
            next_s.st = P_READ;
          end
        end
        default:
        begin
          next_s.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.scl_s <= 2'h3;
      s.sda_s <= 2'h3;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sda_oe = s.oe;
  assign bus.start = s.start;
  assign bus.stop = s.stop;
  assign bus.byte_valid = s.byte_valid;
  assign bus.byte_data = s.shreg;
  assign bus.rd_take = s.rd_take;
endmodule
`default_nettype wire

//--- design/monitor_tag_i2c_access.sv
// Contract
// [R1] Register-write 0x51 to 0x07 selects group; record fills with latest sampled group.
// [R2] Register-read 0x52 at 0x08 returns snapshot of last selected group.
// [R3] Register 0x70 bits 5..2 drive drivers four..one, bits 1..0 outputs three, two.
// [R4] Outputs not under software control ignore their control register bit.
// [R5] Three channels give 11-bit readings split high/low, refreshed while enabled.
// [R6] Reading a high byte holds the matching low bits for the next low read.
// [R7] Host should read high byte before low byte in one transaction.
// [R8] Readings are two's complement, bit 10 sign, quarter degree per step.
// [R9] Disabled or reset channel always reads 0x700, minus sixty-four degrees.
// [R10] Readings above 160 degrees saturate at 0x3FF; no lower clamp.
// [R11] 0x86 and 0x87 give comparator alarms in bits 2..0, upper bits zero.
// [R12] After a read ending at 0x85 or 0x86 host reads another address first.
// [R13] Tag instructions act only when the shared memory is in tag mode.
// [R14] Tag instructions act only in programming mode.
// [R15] 0x61 erases whole array, 0x62 writes tag register, 0x63 reads it back.
// [R16] 0x64 programs selected row from tag register, 0x65 reads selected row.
// [R17] Erase is whole-array only; a row must be erased before programming.
// [R18] Seven-byte volatile tag register and sixteen rows of seven bytes.
// [R19] One 0x62 transaction loads up to seven bytes from byte zero.
// [R20] Tag register read returns up to seven bytes, byte zero first.
// [R21] Row byte bits 7..4 select row; bits 3..0 are zero.
// [R22] Row read address auto-increments across rows; stop ends it anywhere.
// [R23] Bits shown as zero read zero and ignore writes.
`default_nettype none
module monitor_tag_i2c_access
  import mon_tag_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = DEFAULT_TARGET_ADDR,
  parameter int MON_GROUPS = 7,
  parameter int TAG_ROWS = 16,
  parameter int TAG_BYTES = 7
)
(
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic scl_in, // Bus clock pin
  input wire logic sda_in, // Bus data pin level
  output logic sda_out, // Data pin drive value
  output logic sda_oe, // Data pin drive enable
  input wire logic [MON_GROUPS-1:0][7:0] monitor_group, // Sampled monitor groups
  input wire logic [TEMP_CHANNELS-1:0][TEMP_RAW_WIDTH-1:0] temp_raw, // Signed quarter-degree readings
  input wire logic [TEMP_CHANNELS-1:0] temp_enabled, // Channel running
  input wire logic [TEMP_CHANNELS-1:0] temp_alarm_a, // First comparator alarms
  input wire logic [TEMP_CHANNELS-1:0] temp_alarm_b, // Second comparator alarms
  input wire logic [OUT_CTL_WIDTH-1:0] software_controlled, // Output under software control
  input wire logic [OUT_CTL_WIDTH-1:0] control_logic_value, // Value from output control logic
  output logic [OUT_CTL_WIDTH-1:0] output_drive, // Resulting output levels
  input wire logic tag_mode, // Shared memory in tag mode
  output logic programming_mode // Programming mode active
);
  typedef struct packed {
    logic [7:0] instr;
    logic [3:0] byte_idx;
    logic [7:0] reg_addr;
    logic [MON_SELECT_WIDTH-1:0] mon_sel;
    logic mon_valid;
    logic [7:0] mon_record;
    logic [OUT_CTL_WIDTH-1:0] out_ctl;
    logic [OUT_CTL_WIDTH-1:0] drive;
    logic [TEMP_CHANNELS-1:0][2:0] temp_low_hold;
    logic [TEMP_CHANNELS-1:0][10:0] temp_seen;
    logic prog_mode;
    logic key_high_ok;
    logic [TAG_BYTES-1:0][7:0] tag_reg;
    logic [TAG_ROWS-1:0][TAG_BYTES-1:0][7:0] tag_mem;
    logic [TAG_ROWS-1:0] row_erased;
    logic [2:0] tag_ptr;
    logic [3:0] rd_row;
    logic [2:0] rd_byte;
  } core_s_t;

  core_s_t s;
  core_s_t next_s;
  i2c_byte_if bus ();
  logic tag_ok;
  logic [TEMP_CHANNELS-1:0][10:0] temp_code_now;
  logic [7:0] rd_byte_out;

  function automatic logic [10:0] temp_code(input logic [TEMP_RAW_WIDTH-1:0] raw, input logic en);
    logic signed [TEMP_RAW_WIDTH-1:0] sraw;
    sraw = raw;
    if (!en)
      return TEMP_OFF_CODE; // R9
    else if (sraw > TEMP_SAT_LIMIT)
      return TEMP_SAT_CODE; // R10
    else
      return raw[10:0]; // R8
  endfunction

  function automatic logic [1:0] temp_channel(input logic [7:0] addr);
    return addr[2:1];
  endfunction

  function automatic logic is_temp_high(input logic [7:0] addr);
    return addr == ADDR_TEMP_EXT1_HIGH_BYTE || addr == ADDR_TEMP_EXT2_HIGH_BYTE ||
           addr == ADDR_TEMP_INTERNAL_HIGH_BYTE;
  endfunction

  i2c_target_phy #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_phy (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .bus(bus.phy)
  );

  assign tag_ok = s.prog_mode & tag_mode; // R13 R14

  always_comb
  begin
    for (int ch = 0; ch < TEMP_CHANNELS; ch++)
    begin
      temp_code_now[ch] = temp_code(temp_raw[ch], temp_enabled[ch]); // R5
    end
  end

  // Byte presented to the target for the next read slot
  always_comb
  begin
    rd_byte_out = READ_FILL_BYTE;
    case (s.instr)
      INSTR_REG_READ:
      begin
        case (s.reg_addr)
          ADDR_MONITOR_SELECT:
            rd_byte_out = {s.mon_valid, 3'h0, s.mon_sel}; // R23
          ADDR_MONITOR_RECORD:
            rd_byte_out = s.mon_record; // R2
          ADDR_OUTPUT_SOFTWARE_CONTROL:
            rd_byte_out = {2'h0, s.out_ctl}; // R3
          ADDR_TEMP_EXT1_HIGH_BYTE, ADDR_TEMP_EXT2_HIGH_BYTE, ADDR_TEMP_INTERNAL_HIGH_BYTE:
            rd_byte_out = temp_code_now[temp_channel(s.reg_addr)][10:3]; // R5
          ADDR_TEMP_EXT1_LOW_BYTE, ADDR_TEMP_EXT2_LOW_BYTE, ADDR_TEMP_INTERNAL_LOW_BYTE:
            rd_byte_out = {s.temp_low_hold[temp_channel(s.reg_addr)], 5'h00}; // R6
          ADDR_TEMP_ALARM_FIRST_COMPARATOR:
            rd_byte_out = {5'h00, temp_alarm_a}; // R11
          ADDR_TEMP_ALARM_SECOND_COMPARATOR:
            rd_byte_out = {5'h00, temp_alarm_b}; // R11
          default:
            rd_byte_out = UNMAPPED_READ_BYTE;
        endcase
      end
      INSTR_TAG_REG_READ:
      begin
        if (tag_ok)
          rd_byte_out = s.tag_reg[s.tag_ptr]; // R20
      end
      INSTR_TAG_ROW_READ:
      begin
        if (tag_ok)
          rd_byte_out = s.tag_mem[s.rd_row][s.rd_byte]; // R16
      end
      default:
        rd_byte_out = READ_FILL_BYTE;
    endcase
  end

  assign bus.rd_data = rd_byte_out;

  always_comb
  begin
    next_s = s;
    // Record follows the live group; valid rises one cycle after a new select
    next_s.mon_valid = 1'b1; // R1
    next_s.mon_record = (int'(s.mon_sel) < MON_GROUPS) ? monitor_group[s.mon_sel] : 8'h00; // R1
    // Codes as the target latched them; the take strobe arrives a cycle later
    next_s.temp_seen = temp_code_now; // R6
    for (int b = 0; b < OUT_CTL_WIDTH; b++)
    begin
      next_s.drive[b] = software_controlled[b] ? s.out_ctl[b] : control_logic_value[b]; // R4
    end
    if (bus.start)
    begin
      next_s.byte_idx = 4'h0;
    end
    else if (bus.byte_valid)
    begin
      if (s.byte_idx != BYTE_IDX_MAX)
        next_s.byte_idx = s.byte_idx + 4'h1;
      if (s.byte_idx == 4'h0)
      begin
        next_s.instr = bus.byte_data;
        case (bus.byte_data)
          INSTR_EXIT_PROG:
            next_s.prog_mode = 1'b0;
          INSTR_TAG_ERASE:
          begin
            if (tag_ok)
            begin
              next_s.tag_mem = {(TAG_ROWS * TAG_BYTES){TAG_ERASED_BYTE}}; // R15 R17
              next_s.row_erased = '1; // R17
            end
          end
          INSTR_TAG_REG_READ:
            next_s.tag_ptr = 3'h0; // R20
          default:
            next_s.key_high_ok = 1'b0;
        endcase
      end
      else
      begin
        case (s.instr)
          INSTR_ENTER_PROG:
          begin
            if (s.byte_idx == 4'h1)
              next_s.key_high_ok = (bus.byte_data == PROG_KEY_HIGH);
            else if (s.byte_idx == 4'h2 && s.key_high_ok && bus.byte_data == PROG_KEY_LOW)
              next_s.prog_mode = 1'b1; // R14
          end
          INSTR_REG_WRITE:
          begin
            if (s.byte_idx == 4'h1)
            begin
              next_s.reg_addr = bus.byte_data;
            end
            else if (s.byte_idx == 4'h2)
            begin
              if (s.reg_addr == ADDR_MONITOR_SELECT)
              begin
                next_s.mon_sel = bus.byte_data[MON_SELECT_WIDTH-1:0]; // R1 R23
                next_s.mon_valid = 1'b0;
              end
              else if (s.reg_addr == ADDR_OUTPUT_SOFTWARE_CONTROL)
              begin
                next_s.out_ctl = bus.byte_data[OUT_CTL_WIDTH-1:0]; // R3 R23
              end
            end
          end
          INSTR_REG_READ:
          begin
            if (s.byte_idx == 4'h1)
              next_s.reg_addr = bus.byte_data; // R2
          end
          INSTR_TAG_REG_WRITE:
          begin
            if (tag_ok && s.byte_idx <= 4'(TAG_BYTES))
              next_s.tag_reg[s.byte_idx - 4'h1] = bus.byte_data; // R15 R18 R19
          end
          INSTR_TAG_ROW_PROGRAM:
          begin
            if (s.byte_idx == 4'h1 && tag_ok && s.row_erased[bus.byte_data[7:4]] &&
                bus.byte_data[3:0] == 4'h0)
            begin
              next_s.tag_mem[bus.byte_data[7:4]] = s.tag_reg; // R16 R17 R21
              next_s.row_erased[bus.byte_data[7:4]] = 1'b0; // R17
            end
          end
          INSTR_TAG_ROW_READ:
          begin
            if (s.byte_idx == 4'h1)
            begin
              next_s.rd_row = bus.byte_data[7:4]; // R21
              next_s.rd_byte = 3'h0;
            end
          end
          default:
            next_s.key_high_ok = 1'b0;
        endcase
      end
    end
    if (bus.rd_take)
    begin
      case (s.instr)
        INSTR_REG_READ:
        begin
          if (is_temp_high(s.reg_addr))
            next_s.temp_low_hold[temp_channel(s.reg_addr)] = s.temp_seen[temp_channel(s.reg_addr)][2:0]; // R6
          next_s.reg_addr = s.reg_addr + 8'h01;
        end
        INSTR_TAG_REG_READ:
        begin
          if (s.tag_ptr != TAG_LAST_BYTE)
            next_s.tag_ptr = s.tag_ptr + 3'h1; // R20
        end
        INSTR_TAG_ROW_READ:
        begin
          if (s.rd_byte == TAG_LAST_BYTE)
          begin
            next_s.rd_byte = 3'h0;
            next_s.rd_row = s.rd_row + 4'h1; // R22
          end
          else
          begin
            next_s.rd_byte = s.rd_byte + 3'h1; // R22
          end
        end
        default:
          next_s.rd_byte = s.rd_byte;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.tag_mem <= {(TAG_ROWS * TAG_BYTES){TAG_ERASED_BYTE}};
      s.row_erased <= '1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign output_drive = s.drive;
  assign programming_mode = s.prog_mode;
endmodule
`default_nettype wire

//--- bench/mon_tag_checker_assertions.sv
`default_nettype none
module mon_tag_checker
  import mon_tag_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = DEFAULT_TARGET_ADDR,
  parameter int MON_GROUPS = 7,
  parameter int TAG_ROWS = 16,
  parameter int TAG_BYTES = 7
)
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic scl_in, // Bus clock
  input wire logic sda_in, // Bus data
  input wire logic sda_out, // Drive value
  input wire logic sda_oe, // Drive enable
  input wire logic [MON_GROUPS-1:0][7:0] monitor_group, // Groups
  input wire logic [TEMP_CHANNELS-1:0][TEMP_RAW_WIDTH-1:0] temp_raw, // Readings
  input wire logic [TEMP_CHANNELS-1:0] temp_enabled, // Enables
  input wire logic [TEMP_CHANNELS-1:0] temp_alarm_a, // Alarms A
  input wire logic [TEMP_CHANNELS-1:0] temp_alarm_b, // Alarms B
  input wire logic [OUT_CTL_WIDTH-1:0] software_controlled, // Mask
  input wire logic [OUT_CTL_WIDTH-1:0] control_logic_value, // Hardware value
  input wire logic [OUT_CTL_WIDTH-1:0] output_drive, // Outputs
  input wire logic tag_mode, // Tag mode
  input wire logic programming_mode // Programming mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  AST_RESET_CLEAR: assert property (!$past(rst_n) |-> !sda_oe && !programming_mode && output_drive == '0)
    else $error("state not cleared by reset");
  AST_HW_FOLLOW: assert property ($past(rst_n) && $past(rst_n, 2) |->
    ((output_drive ^ $past(control_logic_value)) & ~$past(software_controlled)) == '0)
    else $error("hardware controlled output wrong");
  AST_SW_QUIET: assert property (scl_in && $past(rst_n) && $past(rst_n, 2) |->
    ((output_drive ^ $past(output_drive)) & $past(software_controlled) & $past(software_controlled, 2)) == '0)
    else $error("software output changed outside a write");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed while clock high");
  AST_OE_HELD: assert property ($rose(scl_in) |-> ##1 $stable(sda_oe) [*4])
    else $error("data drive moved after clock rise");
  AST_PROG_RISE: assert property ($rose(programming_mode) |-> !scl_in)
    else $error("programming mode set outside a byte end");
  AST_PROG_ACK: assert property ($rose(programming_mode) |-> ##[0:6] sda_oe)
    else $error("programming mode set without ack");
  cover property ($rose(programming_mode));
  cover property ($fell(sda_oe));
  cover property ($changed(output_drive));
endmodule

bind monitor_tag_i2c_access mon_tag_checker #(.TARGET_ADDR(TARGET_ADDR), .MON_GROUPS(MON_GROUPS),
  .TAG_ROWS(TAG_ROWS), .TAG_BYTES(TAG_BYTES)) i_mon_tag_checker (.clk(clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .monitor_group(monitor_group),
  .temp_raw(temp_raw), .temp_enabled(temp_enabled), .temp_alarm_a(temp_alarm_a), .temp_alarm_b(temp_alarm_b),
  .software_controlled(software_controlled), .control_logic_value(control_logic_value),
  .output_drive(output_drive), .tag_mode(tag_mode), .programming_mode(programming_mode));
`default_nettype wire

//--- bench/i2c_host.sv
`default_nettype none
module i2c_host
(
  input wire logic clk, // System clock
  input wire logic sda, // Resolved data wire
  output logic scl, // Bus clock
  output logic sda_oe // Pull data low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hp();
    repeat (8) @(posedge clk);
  endtask
  // Also serves as repeated start
  task automatic start();
    repeat (2) @(posedge clk);
    sda_oe <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe <= 1'b1;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge clk);
    sda_oe <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe <= 1'b0;
    hp();
  endtask
  // Eight bits then the ack slot; a high releases it
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r);
    for (int i = 7; i >= -1; i--)
    begin
      repeat (2) @(posedge clk);
      sda_oe <= (i < 0) ? !a : !w[i];
      hp();
      scl <= 1'b1;
      hp();
      if (i >= 0)
        r[i] = sda;
      scl <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`default_nettype none
module tb;
  import mon_tag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tag_mode = 1'b0;
  logic scl, m_oe, sda, sda_oe, sda_out, programming_mode, en;
  logic [6:0][7:0] monitor_group = '0;
  logic [2:0][11:0] temp_raw = '0;
  logic [2:0] temp_enabled = '0, temp_alarm_a = '0, temp_alarm_b = '0;
  logic [5:0] software_controlled = '0, control_logic_value = '0, output_drive;
  logic [7:0] v, wq[$], rq[$], d[7];
  logic [10:0] e;
  logic [11:0] r;
  logic [31:0] seed = 32'h6ad20c3b;
  int n_fail = 0, tests_run = 0, c;
  assign sda = !(m_oe || sda_oe);
  always #50 clk = !clk;
  i2c_host i_i2c_host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  monitor_tag_i2c_access i_monitor_tag_i2c_access
  (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .monitor_group(monitor_group), .temp_raw(temp_raw), .temp_enabled(temp_enabled),
    .temp_alarm_a(temp_alarm_a), .temp_alarm_b(temp_alarm_b), .software_controlled(software_controlled),
    .control_logic_value(control_logic_value), .output_drive(output_drive), .tag_mode(tag_mode),
    .programming_mode(programming_mode)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [10:0] tcode(input logic [11:0] x, input logic on);
    if (!on)
      return 11'h700;
    if ($signed(x) > 640)
      return 11'h3ff;
    return x[10:0];
  endfunction
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sends wq after the address, then reads nr bytes after a repeated start
  task automatic tx(input int nr);
    logic [7:0] b;
    rq = {};
    i_i2c_host.start();
    i_i2c_host.xfer({DEFAULT_TARGET_ADDR, 1'b0}, 1'b1, b);
    foreach (wq[i])
      i_i2c_host.xfer(wq[i], 1'b1, b);
    if (nr > 0)
    begin
      i_i2c_host.start();
      i_i2c_host.xfer({DEFAULT_TARGET_ADDR, 1'b1}, 1'b1, b);
      for (int i = 0; i < nr; i++)
      begin
        i_i2c_host.xfer(8'hff, i == nr - 1, b);
        rq.push_back(b);
      end
    end
    i_i2c_host.stop();
  endtask
  task automatic tread(input logic [7:0] a, input int n);
    logic [7:0] q[$];
    wq = {INSTR_REG_READ, a};
    tx(n);
    if (8'(a + n - 1) inside {8'h85, 8'h86})
    begin
      q = rq;
      wq = {INSTR_REG_READ, ADDR_OUTPUT_SOFTWARE_CONTROL};
      tx(1);
      rq = q;
    end
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(programming_mode, 8'h00);
    tread(ADDR_OUTPUT_SOFTWARE_CONTROL, 1);
    chk(rq[0], 8'h00);
    tread(8'h30, 1);
    chk(rq[0], UNMAPPED_READ_BYTE);
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'hff : 8'(rnd());
      software_controlled <= 6'(rnd());
      control_logic_value <= 6'(rnd());
      wq = {INSTR_REG_WRITE, ADDR_OUTPUT_SOFTWARE_CONTROL, v};
      tx(0);
      tread(ADDR_OUTPUT_SOFTWARE_CONTROL, 1);
      chk(rq[0], {2'b00, v[5:0]});
      chk(output_drive, (software_controlled & v[5:0]) | (~software_controlled & control_logic_value));
    end
    for (int g = 0; g < 7; g++)
    begin
      monitor_group[g] <= 8'(rnd());
      wq = {INSTR_REG_WRITE, ADDR_MONITOR_SELECT, 8'(g) | 8'h70};
      tx(0);
      tread(ADDR_MONITOR_RECORD, 1);
      chk(rq[0], monitor_group[g]);
    end
    tread(ADDR_MONITOR_SELECT, 1);
    chk(rq[0], 8'h86);
    // Saturation edge, boundary, negative, random, disabled per channel
    for (int k = 0; k < 15; k++)
    begin
      c = k % 3;
      r = (k < 3) ? 12'h281 : (k < 6) ? 12'h280 : (k < 9) ? 12'he00 : 12'(rnd() % 1536 - 512);
      en = k < 12;
      temp_raw[c] <= r;
      temp_enabled[c] <= en;
      e = tcode(r, en);
      @(posedge clk);
      tread(8'(8'h80 + 2 * c), 2);
      chk(rq[0], e[10:3]);
      chk(rq[1], {e[2:0], 5'b0});
      temp_raw[c] <= ~r;
      @(posedge clk);
      tread(8'(8'h81 + 2 * c), 1);
      chk(rq[0], {e[2:0], 5'b0});
    end
    temp_alarm_a <= 3'(rnd());
    temp_alarm_b <= 3'(rnd());
    @(posedge clk);
    tread(ADDR_TEMP_ALARM_FIRST_COMPARATOR, 2);
    chk(rq[0], {5'b0, temp_alarm_a});
    chk(rq[1], {5'b0, temp_alarm_b});
    tag_mode <= 1'b1;
    wq = {INSTR_TAG_REG_READ};
    tx(1);
    chk(rq[0], READ_FILL_BYTE);
    wq = {INSTR_ENTER_PROG, PROG_KEY_HIGH, PROG_KEY_LOW};
    tx(0);
    chk(programming_mode, 8'h01);
    tag_mode <= 1'b0;
    wq = {INSTR_TAG_REG_WRITE, 8'h11};
    tx(0);
    wq = {INSTR_TAG_REG_READ};
    tx(1);
    chk(rq[0], READ_FILL_BYTE);
    tag_mode <= 1'b1;
    tx(1);
    chk(rq[0], 8'h00);
    wq = {INSTR_TAG_REG_WRITE};
    for (int i = 0; i < 7; i++)
    begin
      d[i] = 8'(rnd());
      wq.push_back(d[i]);
    end
    wq.push_back(8'h5a);
    tx(0);
    wq = {INSTR_TAG_REG_READ};
    tx(8);
    for (int i = 0; i < 8; i++)
      chk(rq[i], d[i < 7 ? i : 6]);
    wq = {INSTR_TAG_ERASE};
    tx(0);
    wq = {INSTR_TAG_ROW_PROGRAM, 8'h40};
    tx(0);
    wq = {INSTR_TAG_ROW_PROGRAM, 8'h31};
    tx(0);
    wq = {INSTR_TAG_REG_WRITE, 8'h00};
    tx(0);
    wq = {INSTR_TAG_ROW_PROGRAM, 8'h40};
    tx(0);
    wq = {INSTR_TAG_ROW_READ, 8'h30};
    tx(14);
    for (int i = 0; i < 14; i++)
      chk(rq[i], i < 7 ? TAG_ERASED_BYTE : d[i - 7]);
    wq = {INSTR_TAG_ERASE};
    tx(0);
    wq = {INSTR_TAG_ROW_READ, 8'h40};
    tx(1);
    chk(rq[0], TAG_ERASED_BYTE);
    wq = {INSTR_EXIT_PROG};
    tx(0);
    chk(programming_mode, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
